// [design/sorc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module sorc_ctrl #(
    parameter int SETTLE_CYC = sorc_pkg::SETTLE_CYC_DEF,
    parameter int PULSE_CYC = sorc_pkg::SYNC_PULSE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic start_b_i,
    input wire logic sync_in_i,
    output logic sync_out_o,
    output logic filter_reset_o,
    output logic data_hold_o,
    input wire logic conv_done_i,
    output logic new_sample_flag_pin_o,
    output logic core_reset_o,
    output logic [7:0] dctrl_o
);
    // ========================================
    // Serial link domain
    logic [sorc_pkg::CNT_W-1:0] bit_cnt_reg;
    logic [sorc_pkg::FRAME_BITS-2:0] shift_reg;
    logic [sorc_pkg::FRAME_BITS-1:0] word_reg;
    logic evt_tgl_reg;
    logic [sorc_pkg::FRAME_BITS-1:0] resp_reg;

    // The counter is cleared by the frame select, because the link clock does not run between frames.
    always_ff @(posedge sclk_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            bit_cnt_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sclk_i) begin
        shift_reg <= {shift_reg[sorc_pkg::FRAME_BITS-3:0], mosi_i};
    end

    // The command word is taken at the last rising edge of the frame.
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            evt_tgl_reg <= 1'b0;
        end else if (bit_cnt_reg == sorc_pkg::CNT_W'(sorc_pkg::FRAME_BITS - 1)) begin
            evt_tgl_reg <= ~evt_tgl_reg;
        end
    end

    always_ff @(posedge sclk_i) begin
        if (bit_cnt_reg == sorc_pkg::CNT_W'(sorc_pkg::FRAME_BITS - 1)) begin
            word_reg <= {shift_reg, mosi_i};
        end
    end

    // The answer word is settled in the system domain between frames, so the host must leave a gap.
    assign miso_o = resp_reg[sorc_pkg::CNT_W'(sorc_pkg::FRAME_BITS - 1) - bit_cnt_reg];
    assign miso_oe_o = ~cs_b_i;

    // ========================================
    // Crossings into the system domain
    logic evt_s1_reg;
    logic evt_s2_reg;
    logic evt_s3_reg;
    logic start_s1_reg;
    logic start_s2_reg;
    logic start_s3_reg;
    logic syncin_s1_reg;
    logic syncin_s2_reg;
    logic syncin_s3_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            evt_s1_reg <= 1'b0;
            evt_s2_reg <= 1'b0;
            evt_s3_reg <= 1'b0;
            start_s1_reg <= 1'b1;
            start_s2_reg <= 1'b1;
            start_s3_reg <= 1'b1;
            syncin_s1_reg <= 1'b0;
            syncin_s2_reg <= 1'b0;
            syncin_s3_reg <= 1'b0;
        end else begin
            evt_s1_reg <= evt_tgl_reg;
            evt_s2_reg <= evt_s1_reg;
            evt_s3_reg <= evt_s2_reg;
            start_s1_reg <= start_b_i;
            start_s2_reg <= start_s1_reg;
            start_s3_reg <= start_s2_reg;
            syncin_s1_reg <= sync_in_i;
            syncin_s2_reg <= syncin_s1_reg;
            syncin_s3_reg <= syncin_s2_reg;
        end
    end

    logic cmd_evt;
    logic cmd_wr;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_data;
    logic dctrl_wr;
    logic start_fall;
    logic syncin_rise;

    assign cmd_evt = evt_s2_reg ^ evt_s3_reg;
    assign cmd_wr = ~word_reg[sorc_pkg::RW_BIT];
    assign cmd_addr = word_reg[sorc_pkg::ADDR_MSB:sorc_pkg::ADDR_LSB];
    assign cmd_data = word_reg[sorc_pkg::DATA_MSB:0];
    assign dctrl_wr = cmd_evt & cmd_wr & (cmd_addr == sorc_pkg::DCTRL_ADDR);
    assign start_fall = start_s3_reg & ~start_s2_reg;
    assign syncin_rise = syncin_s2_reg & ~syncin_s3_reg;

    // ========================================
    // Soft reset sequencer
    sorc_pkg::sorc_sr_state_t sr_state_reg;
    logic soft_rst;

    assign soft_rst = dctrl_wr && (sr_state_reg == sorc_pkg::SR_ARMED)
        && (cmd_data[sorc_pkg::RST_MSB:sorc_pkg::RST_LSB] == sorc_pkg::CODE_SECOND);

    // Any write in between, except the first code again, drops the armed state, so a lone second code does nothing.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sr_state_reg <= sorc_pkg::SR_IDLE;
        end else if (cmd_evt && cmd_wr) begin
            unique case (sr_state_reg)
                sorc_pkg::SR_IDLE: begin
                    if (dctrl_wr && cmd_data[sorc_pkg::RST_MSB:sorc_pkg::RST_LSB] == sorc_pkg::CODE_FIRST) begin
                        sr_state_reg <= sorc_pkg::SR_ARMED;
                    end
                end
                sorc_pkg::SR_ARMED: begin
                    if (dctrl_wr && cmd_data[sorc_pkg::RST_MSB:sorc_pkg::RST_LSB] == sorc_pkg::CODE_FIRST) begin
                        sr_state_reg <= sorc_pkg::SR_ARMED;
                    end else begin
                        sr_state_reg <= sorc_pkg::SR_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            core_reset_o <= 1'b0;
        end else begin
            core_reset_o <= soft_rst;
        end
    end

    // ========================================
    // Data control register
    logic [7:0] dctrl_reg;
    logic sw_sync;

    assign sw_sync = dctrl_wr & ~soft_rst & ~dctrl_reg[sorc_pkg::SYNC_BIT] & cmd_data[sorc_pkg::SYNC_BIT];

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || soft_rst) begin
            dctrl_reg <= sorc_pkg::DCTRL_RESET;
        end else if (dctrl_wr) begin
            dctrl_reg <= cmd_data & sorc_pkg::DCTRL_WMASK;
        end
    end

    assign dctrl_o = dctrl_reg;

    // ========================================
    // Answer word for the next frame
    logic rst_resp_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rst_resp_reg <= 1'b0;
        end else if (soft_rst) begin
            rst_resp_reg <= 1'b1;
        end else if (cmd_evt) begin
            rst_resp_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || soft_rst) begin
            resp_reg <= sorc_pkg::RESP_IDLE;
        end else if (cmd_evt) begin
            if (rst_resp_reg) begin
                resp_reg <= sorc_pkg::SOFT_RESET_RESP;
            end else if (!cmd_wr && cmd_addr == sorc_pkg::DCTRL_ADDR) begin
                resp_reg <= {sorc_pkg::RESP_HDR, dctrl_reg};
            end else begin
                resp_reg <= sorc_pkg::RESP_IDLE;
            end
        end
    end

    // ========================================
    // Sync output pulse
    logic [7:0] pulse_cnt_reg;

    // A software sync and a start pin pulse share this one path, so they cannot differ.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pulse_cnt_reg <= '0;
        end else if (sw_sync || start_fall) begin
            pulse_cnt_reg <= 8'(PULSE_CYC);
        end else if (pulse_cnt_reg != '0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            sync_out_o <= 1'b0;
        end else begin
            sync_out_o <= (sw_sync || start_fall || pulse_cnt_reg > 8'h01);
        end
    end

    // ========================================
    // Filter reset, settling and result release
    logic [15:0] settle_cnt_reg;
    logic shot_pend_reg;
    logic release_ok;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            filter_reset_o <= 1'b0;
        end else begin
            filter_reset_o <= syncin_rise;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            settle_cnt_reg <= '0;
        end else if (syncin_rise) begin
            settle_cnt_reg <= 16'(SETTLE_CYC);
        end else if (settle_cnt_reg != '0) begin
            settle_cnt_reg <= settle_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            data_hold_o <= 1'b0;
        end else begin
            data_hold_o <= syncin_rise || (settle_cnt_reg > 16'h0001);
        end
    end

    assign release_ok = conv_done_i & ~data_hold_o
        & (~dctrl_reg[sorc_pkg::ONESHOT_BIT] | shot_pend_reg);

    // A new edge wins over the clear made by the result it releases.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || !dctrl_reg[sorc_pkg::ONESHOT_BIT]) begin
            shot_pend_reg <= 1'b0;
        end else if (syncin_rise) begin
            shot_pend_reg <= 1'b1;
        end else if (release_ok) begin
            shot_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            new_sample_flag_pin_o <= 1'b0;
        end else begin
            new_sample_flag_pin_o <= release_ok;
        end
    end
endmodule : sorc_ctrl
`default_nettype wire

// [design/sorc_pkg.sv]
// What this block does
// - The sync command is taken at the last rising serial clock edge of a frame that moves the sync bit from zero to one and does not complete the reset pair.
// - A taken sync command leaves on the sync output pin as a pulse timed by the master clock.
// - A software sync behaves exactly like a pulse on the start pin.
// - Every pulse on the sync input pin resets the digital filters.
// - After a filter reset no data is released until the full settling time has passed.
// - With one-shot enabled, one result is released per rising edge on the sync input; clearing the bit ends the mode.
// - The complete ordered reset pair resets the digital core and returns the data control register to its default.
// - After a soft reset the first command is answered in the following frame with the word 0x0E00.
// - The data control register resets to 0x80: sync bit one, one-shot and reset field zero.
package sorc_pkg;
    // ========================================
    // Serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 4;
    localparam int RW_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam logic [7:0] RESP_HDR = 8'h00;
    localparam logic [15:0] RESP_IDLE = 16'h0000;
    localparam logic [15:0] SOFT_RESET_RESP = 16'h0E00;
    // ========================================
    // Data control register
    localparam logic [6:0] DCTRL_ADDR = 7'h06;
    localparam logic [7:0] DCTRL_RESET = 8'h80;
    localparam logic [7:0] DCTRL_WMASK = 8'h93;
    localparam int SYNC_BIT = 7;
    localparam int ONESHOT_BIT = 4;
    localparam int RST_MSB = 1;
    localparam int RST_LSB = 0;
    localparam logic [1:0] CODE_FIRST = 2'h3;
    localparam logic [1:0] CODE_SECOND = 2'h2;
    // ========================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SYNC_PULSE_NS = 100;
    localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC_DEF = 64;
    // ========================================
    // Soft reset sequencer
    typedef enum logic [0:0] {
        SR_IDLE = 1'b0,
        SR_ARMED = 1'b1
    } sorc_sr_state_t;
endpackage : sorc_pkg

// [verif/sorc_ctrl_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Checker on the control block ports.
module sorc_ctrl_sva #(
    parameter int SETTLE_CYC = sorc_pkg::SETTLE_CYC_DEF,
    parameter int PULSE_CYC = sorc_pkg::SYNC_PULSE_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic sync_out_o,
    input wire logic filter_reset_o,
    input wire logic data_hold_o,
    input wire logic conv_done_i,
    input wire logic new_sample_flag_pin_o,
    input wire logic core_reset_o,
    input wire logic [7:0] dctrl_o
);
    int hold_cnt;
    int sync_cnt;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // Run lengths are counted here because the counts are parameters.
    always_ff @(posedge clk_sys_i) begin
        hold_cnt <= (rst_b_i && data_hold_o) ? hold_cnt + 1 : 0;
    end
    always_ff @(posedge clk_sys_i) begin
        sync_cnt <= (rst_b_i && sync_out_o) ? sync_cnt + 1 : 0;
    end
    sequence s_hold_start;
        ##[0:1] data_hold_o;
    endsequence
    sequence s_defaults_back;
        ##[0:1] (dctrl_o == sorc_pkg::DCTRL_RESET);
    endsequence
    a_sync_pulse_len: assert property ($fell(sync_out_o) |-> sync_cnt == PULSE_CYC)
        else $error("sync pulse width wrong");
    a_hold_length: assert property ($fell(data_hold_o) |-> hold_cnt == SETTLE_CYC)
        else $error("settle hold length wrong");
    a_filter_one_cycle: assert property (filter_reset_o |=> !filter_reset_o)
        else $error("filter reset not a single pulse");
    a_hold_follows_filter: assert property (filter_reset_o |-> s_hold_start)
        else $error("no settle hold after filter reset");
    a_flag_has_cause: assert property (new_sample_flag_pin_o |-> $past(conv_done_i) && !$past(data_hold_o))
        else $error("result released without cause");
    a_core_one_cycle: assert property (core_reset_o |=> !core_reset_o)
        else $error("core reset not a single pulse");
    a_core_defaults: assert property (core_reset_o |-> s_defaults_back)
        else $error("register not back to default");
    a_reserved_zero: assert property ((dctrl_o & ~sorc_pkg::DCTRL_WMASK) == 8'h00)
        else $error("reserved bits not zero");
endmodule : sorc_ctrl_sva
bind sorc_ctrl sorc_ctrl_sva #(.SETTLE_CYC(SETTLE_CYC), .PULSE_CYC(PULSE_CYC)) i_sorc_ctrl_sva (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sync_out_o(sync_out_o), .filter_reset_o(filter_reset_o),
    .data_hold_o(data_hold_o), .conv_done_i(conv_done_i), .new_sample_flag_pin_o(new_sample_flag_pin_o),
    .core_reset_o(core_reset_o), .dctrl_o(dctrl_o));
`default_nettype wire

// [verif/sorc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Serial host: mode 0, 16-bit frames, clock still between frames.
module sorc_host_model (
    output logic sclk_o,
    output logic cs_b_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial begin
        sclk_o = 1'b0;
        cs_b_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        cs_b_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o = w[i];
            #15;
            r[i] = miso_i;
            sclk_o = 1'b1;
            #15;
            sclk_o = 1'b0;
        end
        #15;
        cs_b_o = 1'b1;
        // A released line shows the inverse so a stale bit is never mistaken for data.
        mosi_o = ~mosi_o;
        #300;
    endtask : xfer
endmodule : sorc_host_model
`default_nettype wire

// [verif/sorc_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sorc_ctrl_tb_top;
    // Reset falls after time zero so the link-side toggle sees a real edge; no link clock runs in reset.
    logic clk_sys_i = 1'b1;
    logic rst_b_i = 1'b1;
    logic start_b = 1'b1;
    logic sync_drv = 1'b0;
    logic conv_done = 1'b0;
    logic sclk, cs_b, mosi, miso, miso_oe, sync_out, filt, hold, flag, core_rst;
    logic [7:0] dctrl;
    logic [15:0] r;
    wire logic sync_in;
    int bad_count = 0, n_checks = 0, cyc = 0, n_sync = 0, n_filt = 0, n_flag = 0, n_core = 0, n_oe = 0, c0, c1;
    // The output pin is looped back to the input pin as on a board.
    assign sync_in = sync_out | sync_drv;
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge sync_out) n_sync++;
    always @(posedge filt) n_filt++;
    always @(posedge flag) n_flag++;
    always @(posedge core_rst) n_core++;
    always @(posedge miso_oe) n_oe++;
    sorc_host_model i_sorc_host_model (.sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso));
    sorc_ctrl #(.SETTLE_CYC(4), .PULSE_CYC(2)) i_sorc_ctrl (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_o(miso_oe), .start_b_i(start_b), .sync_in_i(sync_in), .sync_out_o(sync_out),
        .filter_reset_o(filt), .data_hold_o(hold), .conv_done_i(conv_done), .new_sample_flag_pin_o(flag),
        .core_reset_o(core_rst), .dctrl_o(dctrl));
    // ========================================
    // Shared tasks.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wclk(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : wclk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_sorc_host_model.xfer({1'b0, a, d}, r);
        wclk(6);
    endtask : wr
    task automatic rd(input logic [6:0] a);
        i_sorc_host_model.xfer({1'b1, a, 8'h00}, r);
        i_sorc_host_model.xfer({1'b1, 7'h06, 8'h00}, r);
    endtask : rd
    task automatic pulse(ref logic s, input int n);
        wclk(1);
        s = 1'b1;
        wclk(n);
        s = 1'b0;
        wclk(2);
    endtask : pulse
    // ========================================
    // Scenarios.
    task automatic t_defaults();
        chk("dctrl", 16'(dctrl), 16'h0080);
        chk("miso enable idle", 16'(miso_oe), 16'h0000);
        c0 = n_oe;
        rd(7'h06);
        chk("read 06", r, 16'h0080);
        chk("miso enable frames", 16'(n_oe - c0), 16'h0002);
        rd(7'h07);
        chk("read 07", r, 16'h0000);
    endtask : t_defaults
    task automatic t_sw_sync();
        c0 = n_sync;
        c1 = n_filt;
        // Two syncs as a chained system needs; the repeated one-write must not sync again.
        repeat (2) begin
            wr(7'h06, 8'h00);
            wr(7'h06, 8'h80);
            wr(7'h06, 8'h80);
        end
        wclk(10);
        chk("sync pulses", 16'(n_sync - c0), 16'h0002);
        chk("filter resets", 16'(n_filt - c1), 16'h0002);
    endtask : t_sw_sync
    task automatic t_start_pin();
        c0 = n_sync;
        c1 = n_filt;
        wclk(1);
        start_b = 1'b0;
        wclk(4);
        start_b = 1'b1;
        wclk(10);
        chk("start sync", 16'(n_sync - c0), 16'h0001);
        chk("start filter", 16'(n_filt - c1), 16'h0001);
    endtask : t_start_pin
    task automatic t_oneshot();
        wr(7'h06, 8'h90);
        pulse(sync_drv, 2);
        wclk(10);
        c0 = n_flag;
        pulse(conv_done, 1);
        pulse(conv_done, 1);
        chk("one-shot results", 16'(n_flag - c0), 16'h0001);
        wr(7'h06, 8'h80);
        c0 = n_flag;
        // The result comes straight after the edge, while the settle hold still stands.
        pulse(sync_drv, 2);
        pulse(conv_done, 1);
        chk("held results", 16'(n_flag - c0), 16'h0000);
        wclk(8);
        pulse(conv_done, 1);
        pulse(conv_done, 1);
        chk("free results", 16'(n_flag - c0), 16'h0002);
    endtask : t_oneshot
    task automatic t_bad_order();
        c0 = n_core;
        wr(7'h06, 8'h82);
        wr(7'h06, 8'h81);
        wr(7'h06, 8'h83);
        wr(7'h07, 8'h00);
        wr(7'h06, 8'h82);
        chk("no reset", 16'(n_core - c0), 16'h0000);
        chk("dctrl kept", 16'(dctrl), 16'h0082);
    endtask : t_bad_order
    task automatic t_soft_reset();
        c0 = n_core;
        wr(7'h06, 8'h93);
        wr(7'h06, 8'h02);
        chk("core reset", 16'(n_core - c0), 16'h0001);
        chk("dctrl default", 16'(dctrl), 16'h0080);
        rd(7'h06);
        chk("answer after reset", r, 16'h0E00);
    endtask : t_soft_reset
    initial begin
        wclk(1);
        rst_b_i = 1'b0;
        wclk(16);
        rst_b_i = 1'b1;
        wclk(4);
        t_defaults();
        t_sw_sync();
        t_start_pin();
        t_oneshot();
        t_bad_order();
        t_soft_reset();
        tally_and_finish();
    end
endmodule : sorc_ctrl_tb_top
`default_nettype wire
